// *** verilog/pims_pkg.sv ***
// Shared constants and types for the PHY interrupt mask/status block.
// Assumes a 32-bit Avalon-MM slave port with byte addressing.
package pims_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int             DATA_W        = 16;
  localparam int             ADDR_W        = 10;
  localparam logic [7:0]     IDX_MASK      = 8'h19;
  localparam logic [7:0]     IDX_STATUS    = 8'h1a;
  localparam logic [7:0]     IDX_QUAL_CTRL = 8'h20;
  localparam logic [9:0]     ADDR_MASK      = {IDX_MASK, 2'b00};
  localparam logic [9:0]     ADDR_STATUS    = {IDX_STATUS, 2'b00};
  localparam logic [9:0]     ADDR_QUAL_CTRL = {IDX_QUAL_CTRL, 2'b00};

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int             BIT_SUMMARY   = 15;
  localparam int             BIT_SPEED     = 14;
  localparam int             BIT_DUPLEX    = 12;
  localparam int             BIT_RESERVED  = 6;
  localparam int             BIT_DOWNSHIFT = 2;
  localparam int             BIT_RX_ERR    = 0;
  localparam logic [15:0]    MASK_RESET    = 16'h0000;
  localparam logic [15:0]    STATUS_RESET  = 16'h0000;
  localparam logic [4:0]     QUAL_RESET    = 5'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic [3:0]        be;
  } pims_bus_req_t;

  typedef struct packed {
    logic [3:0] advert;
    logic       anegEnable;
  } pims_qual_ctrl_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } pims_bus_state_t;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_MASK,
    SEL_STATUS,
    SEL_QUAL
  } pims_sel_t;

  // Address decode, shared by read mux and write path
  function automatic pims_sel_t pims_decode(input logic [ADDR_W-1:0] addr);
    case (addr)
      ADDR_MASK:      pims_decode = SEL_MASK;
      ADDR_STATUS:    pims_decode = SEL_STATUS;
      ADDR_QUAL_CTRL: pims_decode = SEL_QUAL;
      default:        pims_decode = SEL_NONE;
    endcase
  endfunction

endpackage

// *** verilog/pims_avalon_slave.sv ***
// Avalon-MM handshake for the interrupt block: one wait state per access.
// Assumes the master holds its request until it sees waitrequest low.
`timescale 1ns/10ps
module pims_avalon_slave
  import pims_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire pims_bus_req_t req,
  input  wire logic [15:0]   readValue,
  output logic               waitrequest,
  output logic [31:0]        readdata,
  output logic               done
);

  pims_bus_state_t state_reg;
  pims_bus_state_t state_next;
  logic            active;

  assign active      = req.read | req.write;
  assign waitrequest = active & (state_reg != BUS_ACK);
  assign done        = active & (state_reg == BUS_ACK);

  always_comb
  begin
    case (state_reg)
      BUS_IDLE: state_next = active ? BUS_ACK : BUS_IDLE;
      BUS_ACK:  state_next = BUS_IDLE;
      default:  state_next = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      state_reg <= BUS_IDLE;
    else
      state_reg <= state_next;
  end

  // Snapshot taken one edge before completion; upper half reads zero
  always_ff @(posedge clock)
  begin
    if (rst)
      readdata <= 32'h0000_0000;
    else if (state_reg == BUS_IDLE && req.read)
      readdata <= {16'h0000, readValue};
  end

endmodule // pims_avalon_slave

// *** verilog/pims_event_qualifier.sv ***
// Gates raw link events by the conditions under which each may assert.
// Assumes event inputs are single-cycle pulses synchronous to clock.
`timescale 1ns/10ps
module pims_event_qualifier
  import pims_pkg::*;
(
  input  wire logic            [14:0] rawEvent,
  input  wire pims_qual_ctrl_t        qual,
  input  wire logic                   rxErCarrierExt,
  output logic                 [14:0] qualEvent
);

  always_comb
  begin
    qualEvent = rawEvent;
    qualEvent[BIT_RESERVED] = 1'b0;
    qualEvent[BIT_SPEED]  = rawEvent[BIT_SPEED] & qual.anegEnable;
    qualEvent[BIT_DUPLEX] = rawEvent[BIT_DUPLEX] & qual.anegEnable;
    qualEvent[BIT_DOWNSHIFT] = rawEvent[BIT_DOWNSHIFT] & (&qual.advert);
    // Carrier extension is not an error, so it must not look like one
    qualEvent[BIT_RX_ERR] = rawEvent[BIT_RX_ERR] & ~rxErCarrierExt;
  end

endmodule // pims_event_qualifier

// *** verilog/pims_irq_ctrl.sv ***
// Interrupt mask and clear-on-read status for one PHY port.
// Assumes one clock, synchronous reset, Avalon-MM register access.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/10ps
module pims_irq_ctrl
  import pims_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        softRst,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [14:0] linkEvent,
  input  wire logic        rxErCarrierExt,
  output logic             irq,
  output logic             mgmtIrqPinOut,
  output logic             mgmtIrqPinOeN
);

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  pims_bus_req_t   busReq;
  pims_sel_t       sel;
  logic [15:0]     readValue;
  logic            busDone;
  logic            wrStrobe;
  logic            rdStrobe;

  assign busReq.read  = avs_read;
  assign busReq.write = avs_write;
  assign busReq.addr  = avs_address;
  assign busReq.wdata = avs_writedata;
  assign busReq.be    = avs_byteenable;
  assign sel          = pims_decode(avs_address);
  assign wrStrobe     = busDone & avs_write;
  assign rdStrobe     = busDone & avs_read;

  pims_avalon_slave u_slave
  (
    .clock       (clock),
    .rst         (rst),
    .req         (busReq),
    .readValue   (readValue),
    .waitrequest (avs_waitrequest),
    .readdata    (avs_readdata),
    .done        (busDone)
  );

  // ----------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------
  pims_qual_ctrl_t qual_reg;
  logic [14:0]     qualEvent;

  pims_event_qualifier u_qual
  (
    .rawEvent       (linkEvent),
    .qual           (qual_reg),
    .rxErCarrierExt (rxErCarrierExt),
    .qualEvent      (qualEvent)
  );

  // ----------------------------------------------------------------
  // Byte-lane write merge
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  be);
    merge16 = old;
    if (be[0])
      merge16[7:0] = wdata[7:0];
    if (be[1])
      merge16[15:8] = wdata[15:8];
  endfunction

  // ----------------------------------------------------------------
  // Mask register
  // ----------------------------------------------------------------
  logic [15:0] mask_reg;
  logic [15:0] mask_next;

  always_comb
  begin
    mask_next = mask_reg;
    if (wrStrobe && sel == SEL_MASK)
      mask_next = merge16(mask_reg, avs_writedata, avs_byteenable);
  end

  // Soft reset deliberately does not touch the mask
  always_ff @(posedge clock)
  begin
    if (rst)
      mask_reg <= MASK_RESET;
    else
      mask_reg <= mask_next;
  end

  // ----------------------------------------------------------------
  // Qualifier control register
  // ----------------------------------------------------------------
  logic [15:0] qualWide;

  always_comb
  begin
    qualWide = merge16({11'h000, qual_reg}, avs_writedata, avs_byteenable);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      qual_reg <= QUAL_RESET;
    else if (wrStrobe && sel == SEL_QUAL)
      qual_reg <= qualWide[4:0];
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  logic [14:0] status_reg;
  logic [14:0] status_next;
  logic [14:0] reported;
  logic        summary;

  // Only bits handed out in the read snapshot are cleared, so an event
  // landing during the access stays pending
  assign reported = (rdStrobe && sel == SEL_STATUS) ? avs_readdata[14:0] : 15'h0000;

  always_comb
  begin
    status_next = (status_reg & ~reported) | qualEvent;
    status_next[BIT_RESERVED] = 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst || softRst)
      status_reg <= STATUS_RESET[14:0];
    else
      status_reg <= status_next;
  end

  // Summary clears with its causes because it is derived, not stored
  assign summary = |(status_reg & mask_reg[14:0]);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    case (sel)
      SEL_MASK:   readValue = mask_reg;
      SEL_STATUS: readValue = {summary, status_reg};
      SEL_QUAL:   readValue = {11'h000, qual_reg};
      default:    readValue = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------
  // Open-drain pin: always drives low when enabled, floats otherwise
  assign mgmtIrqPinOut = 1'b0;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      irq           <= 1'b0;
      mgmtIrqPinOeN <= 1'b1;
    end
    else
    begin
      irq           <= summary;
      mgmtIrqPinOeN <= ~(mask_reg[BIT_SUMMARY] & summary);
    end
  end

endmodule // pims_irq_ctrl

// *** tb/pims_irq_ctrl_asserts.sv ***
// Port assertions for the interrupt mask/status block.
// Assumes mask writes arrive only through the Avalon port.
`timescale 1ns/10ps
module pims_irq_ctrl_asserts
  import pims_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        softRst,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [14:0] linkEvent,
  input wire logic        irq,
  input wire logic        mgmtIrqPinOeN
);
  // ----
  // Mask shadow, needed because the mask is not visible at the ports
  // ----
  logic [15:0] maskReg;
  always_ff @(posedge clock)
  begin
    if (rst)
      maskReg <= 16'h0000;
    else if (avs_write && !avs_waitrequest && avs_address == ADDR_MASK)
      maskReg <= {avs_byteenable[1] ? avs_writedata[15:8] : maskReg[15:8],
                  avs_byteenable[0] ? avs_writedata[7:0] : maskReg[7:0]};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_irq_reset: assert property (disable iff (1'b0) rst |=> !irq && mgmtIrqPinOeN)
    else $error("irq or pin active after reset");
  a_event_irq: assert property (|(linkEvent & maskReg[14:0] & 15'h2fba) ##1 !softRst |-> ##1 irq)
    else $error("masked event did not raise irq");
  a_read_clear: assert property (avs_read && !avs_waitrequest && avs_address == ADDR_STATUS
    && linkEvent == 15'h0 && $past(linkEvent) == 15'h0 |=> ##1 !irq)
    else $error("irq still high after status read");
  a_mask_quiet: assert property ($past(maskReg[14:0]) == 15'h0 |-> !irq)
    else $error("irq with all events masked");
  a_pin_off: assert property (!$past(maskReg[15]) |-> mgmtIrqPinOeN)
    else $error("pin driven while disabled");
  a_pin_follow: assert property ($past(maskReg[15]) |-> mgmtIrqPinOeN == !irq)
    else $error("pin does not follow summary");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  a_data_hi: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0)
    else $error("upper read data not zero");
  a_bit_six: assert property (avs_read && !avs_waitrequest && avs_address == ADDR_STATUS
    |-> !avs_readdata[6])
    else $error("reserved status bit set");
  c_irq: cover property ($rose(irq));
  c_pin: cover property (!mgmtIrqPinOeN);
  c_read: cover property (avs_read && !avs_waitrequest && avs_readdata[15]);
endmodule // pims_irq_ctrl_asserts

bind pims_irq_ctrl pims_irq_ctrl_asserts u_pims_irq_ctrl_asserts (.clock, .rst, .softRst,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .linkEvent, .irq, .mgmtIrqPinOeN);

// *** tb/pims_station.sv ***
// Management station model: Avalon-MM master for register access.
// Assumes the slave ends each wait by dropping waitrequest.
`timescale 1ns/10ps
module pims_station
  import pims_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  output logic      [9:0]  address = 10'h000,
  output logic             read = 1'b0,
  output logic             write = 1'b0,
  output logic      [31:0] writedata = 32'h0,
  output logic      [3:0]  byteenable = 4'h0
);
  // ----
  // Bus cycle; idle address and write data lines show inverted values so stale data never matches
  // ----
  bit hung = 1'b0;
  task automatic access(input logic wr, input logic [9:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= {16'h0000, d};
    byteenable <= 4'h3;
    read <= !wr;
    write <= wr;
    @(posedge clock);
    while (waitrequest !== 1'b0 && n < 40)
    begin
      @(posedge clock);
      n++;
    end
    q = readdata[15:0];
    hung = hung | (n == 40);
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a;
    writedata <= ~{16'h0000, d};
  endtask
  // Stale events are flushed before the pin is armed
  task automatic arm_pin(input logic [15:0] m);
    logic [15:0] q;
    access(1'b0, ADDR_STATUS, 16'h0000, q);
    access(1'b1, ADDR_MASK, m | 16'h8000, q);
  endtask
endmodule // pims_station

// *** tb/pims_irq_ctrl_bench.sv ***
// Self-checking bench for the interrupt mask/status block.
// Assumes the station model owns the register bus.
`timescale 1ns/10ps
module pims_irq_ctrl_bench
  import pims_pkg::*;
;
  logic        clock = 1'b0, rst = 1'b1, softRst = 1'b0, rxErCarrierExt = 1'b0;
  logic [14:0] linkEvent = 15'h0;
  logic [9:0]  busAddr;
  logic [31:0] busWdata, busRdata;
  logic [3:0]  busBe;
  logic        busRead, busWrite, busWait, irq, pinOut, pinOeN;
  int          n_fail = 0;
  int          cmp_count = 0;
  initial forever #2.5 clock = ~clock;
  pims_irq_ctrl u_pims_irq_ctrl (.clock(clock), .rst(rst), .softRst(softRst),
    .avs_address(busAddr), .avs_read(busRead), .avs_write(busWrite),
    .avs_writedata(busWdata), .avs_byteenable(busBe), .avs_readdata(busRdata),
    .avs_waitrequest(busWait), .linkEvent(linkEvent), .rxErCarrierExt(rxErCarrierExt),
    .irq(irq), .mgmtIrqPinOut(pinOut), .mgmtIrqPinOeN(pinOeN));
  pims_station u_pims_station (.clock(clock), .waitrequest(busWait), .readdata(busRdata),
    .address(busAddr), .read(busRead), .write(busWrite), .writedata(busWdata),
    .byteenable(busBe));
  // ----
  // Shared tasks
  // ----
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rw(input int w, input logic [9:0] a, input int d,
                    output logic [15:0] q);
    u_pims_station.access(w != 0, a, d[15:0], q);
    if (u_pims_station.hung)
    begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic pulse(input int i);
    @(posedge clock);
    linkEvent <= 15'h0001 << i;
    @(posedge clock);
    linkEvent <= 15'h0000;
    repeat (3) @(posedge clock);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset_mask;
    logic [15:0] q;
    rw(0, ADDR_STATUS, 0, q);
    check("status reset", 16'h0000, q);
    check("pin reset", 16'h0001, {14'h0, irq, pinOeN});
    check("pin drive level", 16'h0000, {15'h0, pinOut});
    rw(0, ADDR_MASK, 0, q);
    check("mask reset", 16'h0000, q);
    rw(1, ADDR_MASK, 16'hffff, q);
    rw(1, 10'h3fc, 16'h1234, q);
    rw(0, 10'h3fc, 0, q);
    check("unmapped read", 16'h0000, q);
    @(posedge clock);
    softRst <= 1'b1;
    @(posedge clock);
    softRst <= 1'b0;
    rw(0, ADDR_MASK, 0, q);
    check("mask after soft reset", 16'hffff, q);
    rw(1, ADDR_STATUS, 16'hffff, q);
    rw(0, ADDR_STATUS, 0, q);
    check("status read-only", 16'h0000, q);
    $display("test reset and mask done");
  endtask
  task automatic t_events;
    logic [15:0] q;
    rw(1, ADDR_QUAL_CTRL, 16'h001f, q);
    u_pims_station.arm_pin(16'h7fff);
    for (int i = 0; i < 15; i++)
    begin
      pulse(i);
      check("irq", {15'h0, i != 6}, {15'h0, irq});
      check("pin", {15'h0, i == 6}, {15'h0, pinOeN});
      rw(0, ADDR_STATUS, 0, q);
      check("cause", (i == 6) ? 16'h0 : (16'h8000 | (16'h1 << i)), q);
      rw(0, ADDR_STATUS, 0, q);
      check("cleared", 16'h0000, q);
    end
    $display("test events done");
  endtask
  task automatic t_gates;
    logic [15:0] q;
    rw(1, ADDR_MASK, 16'h2000, q);
    pulse(13);
    pulse(9);
    check("pin held off", 16'h0003, {14'h0, irq, pinOeN});
    rw(0, ADDR_STATUS, 0, q);
    check("polled status", 16'ha200, q);
    pulse(9);
    check("unmasked quiet", 16'h0000, {15'h0, irq});
    rw(0, ADDR_STATUS, 0, q);
    check("unmasked status", 16'h0200, q);
    rxErCarrierExt <= 1'b1;
    pulse(0);
    rxErCarrierExt <= 1'b0;
    rw(1, ADDR_QUAL_CTRL, 16'h0001, q);
    pulse(2);
    rw(1, ADDR_QUAL_CTRL, 16'h001e, q);
    pulse(14);
    pulse(12);
    rw(0, ADDR_STATUS, 0, q);
    check("gated events", 16'h0000, q);
    $display("test gates done");
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_reset_mask();
    t_events();
    t_gates();
    tally_and_finish();
  end
endmodule // pims_irq_ctrl_bench
